// ---- dv/test_analog_comparator_control.sv ----
module test_analog_comparator_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic            clk     = 1'b0;
    logic            rst     = 1'b1;
    logic            hsel    = 1'b0;
    logic [31:0]     haddr   = 32'h0;
    logic [1:0]      htrans  = 2'h0;
    logic            hwrite  = 1'b0;
    logic [2:0]      hsize   = 3'h2;
    logic [31:0]     hwdata  = 32'h0;
    logic [2:0]      raw     = 3'h0;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic            hresp;
    logic [2:0]      comparator_on;
    logic [2:0]      plus;
    logic [2:0][4:0] route;
    logic [2:0]      pin;
    logic [2:0]      pin_oe;
    logic [2:0]      flag;
    logic            irq;
    int              fail_count = 0;
    int              tests_run  = 0;

    comparator_control comparator_control_inst (
        .clk_in                 (clk),
        .rst_in                 (rst),
        .hsel_in                (hsel),
        .haddr_in               (haddr),
        .htrans_in              (htrans),
        .hwrite_in              (hwrite),
        .hsize_in               (hsize),
        .hwdata_in              (hwdata),
        .hready_in              (hreadyout),
        .hrdata_out             (hrdata),
        .hreadyout_out          (hreadyout),
        .hresp_out              (hresp),
        .raw_result_in          (raw),
        .comparator_on_out      (comparator_on),
        .plus_source_select_out (plus),
        .minus_route_out        (route),
        .result_pin_out         (pin),
        .result_pin_oe_out      (pin_oe),
        .edge_event_flag_out    (flag),
        .irq_out                (irq)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    // The slave may stretch a phase; wait on hready but never forever.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            fail_count++;
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, addr};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        wait_ready();
        rdata = hrdata;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] d;
        bus(1'b1, addr, data, d);
    endtask

    task automatic rd(input string name, input logic [7:0] addr,
                      input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, addr, 32'h0, d);
        check(name, exp, d);
        check("hresp", 32'h0, 32'(hresp));
    endtask

    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    task automatic set_raw(input int c, input logic v);
        @(posedge clk);
        raw[c] <= v;
        settle();
    endtask

    task automatic clear_events();
        wr(comparator_pkg::FLAG_OFFSET, 32'h0);
        wr(comparator_pkg::IST_OFFSET, 32'h7);
        @(posedge clk);
        check("irq clear", 32'h0, 32'(irq));
    endtask

    function automatic logic [7:0] ctrl_addr(input int c);
        return comparator_pkg::CTRL0_OFFSET + 8'(4 * c);
    endfunction

    task automatic reset_values();
        for (int c = 0; c < 3; c++) begin
            rd("ctrl reset", ctrl_addr(c), 32'h0);
        end
        check("on after reset", 32'h0, 32'(comparator_on));
    endtask

    // Raise then lower the raw input of one comparator under one setting.
    task automatic edge_case(input int c, input logic [1:0] sel,
                             input logic inv, input logic er, input logic ef);
        logic [7:0] ctrl;
        logic [31:0] d;
        ctrl = 8'h80 | {3'h0, sel, 3'h0} | (inv ? 8'h20 : 8'h00);
        wr(ctrl_addr(c), 32'(ctrl));
        @(posedge clk);
        if (sel == comparator_pkg::EDGE_ANY) begin
            check("auto flag", 32'h1, 32'(flag[c]));
        end
        settle();
        clear_events();
        set_raw(c, 1'b1);
        // Other comparators may still be inverted, so only bit c is judged.
        bus(1'b0, comparator_pkg::STATUS_OFFSET, 32'h0, d);
        check("status", 32'(!inv),
              32'(d[comparator_pkg::STATUS_LSB + c]));
        check("result pin", 32'(!inv), 32'(pin[c]));
        check("rise flag", 32'(er) << c, 32'(flag));
        rd("ist rise", comparator_pkg::IST_OFFSET, 32'(er) << c);
        check("irq rise", 32'(er), 32'(irq));
        clear_events();
        set_raw(c, 1'b0);
        check("fall flag", 32'(ef) << c, 32'(flag));
        clear_events();
    endtask

    initial begin
        // The sequence needs about six hundred cycles; eight times that is ample.
        repeat (5000) @(posedge clk);
        fail_count++;
        finish_test();
    end

    initial begin
        int idx;
        logic [7:0] ctrl;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        reset_values();
        rd("status reset", comparator_pkg::STATUS_OFFSET, 32'h0);
        rd("mask reset", comparator_pkg::MASK_OFFSET, 32'h0);
        rd("unmapped", 8'h1C, 32'h0);
        $display("test reset done");
        for (int c = 0; c < 3; c++) begin
            for (int code = 0; code < 4; code++) begin
                ctrl = 8'h80 | 8'(code);
                ctrl = ctrl | (code[1] ? 8'h40 : 8'h00);
                ctrl = ctrl | (code[0] ? 8'h04 : 8'h00);
                wr(ctrl_addr(c), 32'(ctrl));
                @(posedge clk);
                idx = (code == 2) ? ((c == 1) ? 3 : 2) : (code == 3 ? 4 : code);
                check("route", 32'(5'h01 << idx), 32'(route[c]));
                check("plus", 32'(code[0]), 32'(plus[c]));
                check("pin oe", 32'(code[1]), 32'(pin_oe[c]));
                check("on", 32'h1, 32'(comparator_on[c]));
                rd("ctrl", ctrl_addr(c), 32'(ctrl));
            end
        end
        wr(ctrl_addr(0), 32'h40);
        @(posedge clk);
        check("pin oe off", 32'h0, 32'(pin_oe[0]));
        check("off", 32'h0, 32'(comparator_on[0]));
        $display("test routes done");
        wr(comparator_pkg::MASK_OFFSET, 32'h7);
        edge_case(0, comparator_pkg::EDGE_NONE, 1'b0, 1'b0, 1'b0);
        edge_case(1, comparator_pkg::EDGE_RISE, 1'b0, 1'b1, 1'b0);
        edge_case(2, comparator_pkg::EDGE_FALL, 1'b0, 1'b0, 1'b1);
        edge_case(0, comparator_pkg::EDGE_RISE, 1'b1, 1'b0, 1'b1);
        edge_case(1, comparator_pkg::EDGE_FALL, 1'b1, 1'b1, 1'b0);
        edge_case(2, comparator_pkg::EDGE_ANY, 1'b0, 1'b1, 1'b1);
        edge_case(0, comparator_pkg::EDGE_ANY, 1'b1, 1'b1, 1'b1);
        $display("test edges done");
        wr(ctrl_addr(0), 32'h08);
        settle();
        clear_events();
        set_raw(0, 1'b1);
        check("frozen pin", 32'h0, 32'(pin[0]));
        check("frozen flag", 32'h0, 32'(flag));
        wr(ctrl_addr(0), 32'h80);
        settle();
        // Comparator one is still inverted with a low input, so it reads one.
        rd("status on", comparator_pkg::STATUS_OFFSET, 32'h60);
        wr(comparator_pkg::STATUS_OFFSET, 32'hFF);
        rd("status ro", comparator_pkg::STATUS_OFFSET, 32'h60);
        $display("test freeze done");
        wr(comparator_pkg::MASK_OFFSET, 32'h0);
        clear_events();
        wr(comparator_pkg::FLAG_OFFSET, 32'h2);
        rd("flag sw set", comparator_pkg::FLAG_OFFSET, 32'h2);
        check("flag out", 32'h2, 32'(flag));
        wr(ctrl_addr(1), 32'h98);
        rd("ist auto", comparator_pkg::IST_OFFSET, 32'h2);
        check("irq masked", 32'h0, 32'(irq));
        wr(comparator_pkg::MASK_OFFSET, 32'h2);
        @(posedge clk);
        check("irq unmasked", 32'h1, 32'(irq));
        wr(comparator_pkg::IST_OFFSET, 32'h2);
        @(posedge clk);
        check("irq cleared", 32'h0, 32'(irq));
        check("flag sticky", 32'h2, 32'(flag));
        $display("test interrupt done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reset_values();
        $display("test second reset done");
        finish_test();
    end
endmodule // test_analog_comparator_control

// ---- logic/comparator_channel.sv ----
module comparator_channel (
    input  wire logic       clk_in,        // System clock.
    input  wire logic       rst_in,        // Asynchronous reset.
    input  wire logic       raw_in,        // Raw analog comparator output.
    input  wire logic       enable_in,     // Comparator switched on.
    input  wire logic       invert_in,     // Output polarity inversion.
    input  wire logic [1:0] edge_sel_in,   // Event edge select.
    output logic            result_out,    // Result after polarity.
    output logic            event_out      // One-cycle event pulse.
);

    typedef struct packed {
        logic [2:0] sync;
        logic       held;
        logic       result;
        logic       event_p;
    } chan_state_type;

    chan_state_type state_reg;
    chan_state_type state_next;

    always_comb begin
        state_next = state_reg;
        state_next.sync = {state_reg.sync[1:0], raw_in};
        // A level is accepted once the last two stages agree; the first
        // stage is never looked at, as it may still be metastable.
        if (enable_in && state_reg.sync[1] == state_reg.sync[2]) begin
            state_next.held = state_reg.sync[2];
        end
        // While off the last accepted level is frozen, so switching off
        // raises no event of its own.
        state_next.result = state_next.held ^ invert_in;
        case (edge_sel_in)
            comparator_pkg::EDGE_RISE: begin
                state_next.event_p = state_next.result & ~state_reg.result;
            end
            comparator_pkg::EDGE_FALL: begin
                state_next.event_p = ~state_next.result & state_reg.result;
            end
            comparator_pkg::EDGE_ANY: begin
                state_next.event_p = state_next.result ^ state_reg.result;
            end
            default: begin
                state_next.event_p = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign result_out = state_reg.result;
    assign event_out  = state_reg.event_p;

    none_event_a : assert property (
        @(posedge clk_in) disable iff (rst_in)
        (edge_sel_in == comparator_pkg::EDGE_NONE) |=> !event_out)
        else $error("event raised with edge select off");

    rise_only_a : assert property (
        @(posedge clk_in) disable iff (rst_in)
        (edge_sel_in == comparator_pkg::EDGE_RISE && $rose(state_next.result))
        |=> event_out && result_out)
        else $error("rising edge did not raise event");

    off_hold_a : assert property (
        @(posedge clk_in) disable iff (rst_in)
        (!enable_in && $stable(invert_in)) |=> $stable(result_out))
        else $error("result moved while comparator off");

    invert_flip_a : assert property (
        @(posedge clk_in) disable iff (rst_in)
        $changed(invert_in) |=> $changed(result_out))
        else $error("polarity change did not flip result");

endmodule // comparator_channel

// ---- logic/comparator_control.sv ----
// The address map and the AHB-Lite register port were decided locally.
module comparator_control #(
    parameter bit SMALL_PACKAGE = 1'b0    // Reduced pin package variant.
) (
    input  wire logic            clk_in,                  // Clock.
    input  wire logic            rst_in,                  // Async reset.
    input  wire logic            hsel_in,                 // Slave select.
    input  wire logic [31:0]     haddr_in,                // Address.
    input  wire logic [1:0]      htrans_in,               // Transfer type.
    input  wire logic            hwrite_in,               // Write.
    input  wire logic [2:0]      hsize_in,                // Size, word only.
    input  wire logic [31:0]     hwdata_in,               // Write data.
    input  wire logic            hready_in,               // Bus ready.
    output logic      [31:0]     hrdata_out,              // Read data.
    output logic                 hreadyout_out,           // Slave ready.
    output logic                 hresp_out,               // Response.
    input  wire logic [2:0]      raw_result_in,           // Raw results.
    output logic      [2:0]      comparator_on_out,       // Power on.
    output logic      [2:0]      plus_source_select_out,  // 1 ladder.
    output logic      [2:0][4:0] minus_route_out,         // Minus one-hot.
    output logic      [2:0]      result_pin_out,          // Pin level.
    output logic      [2:0]      result_pin_oe_out,       // Pin enable.
    output logic      [2:0]      edge_event_flag_out,     // Event flags.
    output logic                 irq_out                  // Interrupt.
);

    typedef struct packed {
        logic [2:0][7:0]                         ctrl;
        logic [2:0]                              flag;
        logic [2:0]                              ist;
        logic [2:0]                              mask;
        logic                                    wr_pend;
        logic [7:0]                              wr_addr;
        logic [7:0]                              rdata;
        logic [2:0][comparator_pkg::ROUTE_W-1:0] route;
        logic                                    irq;
    } ctl_state_type;

    ctl_state_type state_reg;
    ctl_state_type state_next;

    logic [2:0] result_bits;
    logic [2:0] events;
    logic [2:0] auto_set;
    logic       addr_phase;

    // Per-comparator synchroniser, hold and event detector.
    for (genvar i = 0; i < comparator_pkg::NUM_COMP; i++) begin : g_chan
        comparator_channel u_chan (
            .clk_in      (clk_in),
            .rst_in      (rst_in),
            .raw_in      (raw_result_in[i]),
            .enable_in   (state_reg.ctrl[i][comparator_pkg::ON_BIT]),
            .invert_in   (state_reg.ctrl[i][comparator_pkg::INV_BIT]),
            .edge_sel_in (state_reg.ctrl[i][comparator_pkg::EDGE_HI:
                                            comparator_pkg::EDGE_LO]),
            .result_out  (result_bits[i]),
            .event_out   (events[i])
        );
    end

    assign addr_phase = hsel_in && hready_in && htrans_in[1];

    always_comb begin
        state_next = state_reg;
        auto_set = 3'h0;
        state_next.wr_pend = 1'b0;

        // Write data phase: the address was captured one cycle earlier.
        if (state_reg.wr_pend) begin
            if (state_reg.wr_addr == comparator_pkg::CTRL0_OFFSET) begin
                state_next.ctrl[0] = hwdata_in[7:0];
            end else if (state_reg.wr_addr ==
                         comparator_pkg::CTRL1_OFFSET) begin
                state_next.ctrl[1] = hwdata_in[7:0];
            end else if (state_reg.wr_addr ==
                         comparator_pkg::CTRL2_OFFSET) begin
                state_next.ctrl[2] = hwdata_in[7:0];
            end else if (state_reg.wr_addr ==
                         comparator_pkg::FLAG_OFFSET) begin
                // Writing a one raises a flag by hand; a zero clears it.
                state_next.flag = hwdata_in[2:0];
            end else if (state_reg.wr_addr ==
                         comparator_pkg::IST_OFFSET) begin
                state_next.ist = state_reg.ist & ~hwdata_in[2:0];
            end else if (state_reg.wr_addr ==
                         comparator_pkg::MASK_OFFSET) begin
                state_next.mask = hwdata_in[2:0];
            end
            // Status and unmapped offsets drop the write.
            for (int i = 0; i < comparator_pkg::NUM_COMP; i++) begin
                if (state_reg.wr_addr == comparator_pkg::CTRL0_OFFSET +
                        8'(4 * i) &&
                    hwdata_in[comparator_pkg::EDGE_HI:
                              comparator_pkg::EDGE_LO] ==
                        comparator_pkg::EDGE_ANY) begin
                    auto_set[i] = 1'b1;
                end
            end
        end

        // Hardware sets come last so they win over a same-cycle clear.
        state_next.flag = state_next.flag | events | auto_set;
        state_next.ist  = state_next.ist | events | auto_set;

        if (addr_phase) begin
            if (hwrite_in) begin
                state_next.wr_pend = 1'b1;
                state_next.wr_addr = haddr_in[7:0];
            end else begin
                // Read data is taken from the updated copy so a read
                // right behind a write sees the written value.
                if (haddr_in[7:0] == comparator_pkg::CTRL0_OFFSET) begin
                    state_next.rdata = state_next.ctrl[0];
                end else if (haddr_in[7:0] ==
                             comparator_pkg::CTRL1_OFFSET) begin
                    state_next.rdata = state_next.ctrl[1];
                end else if (haddr_in[7:0] ==
                             comparator_pkg::CTRL2_OFFSET) begin
                    state_next.rdata = state_next.ctrl[2];
                end else if (haddr_in[7:0] ==
                             comparator_pkg::STATUS_OFFSET) begin
                    state_next.rdata = {result_bits, 5'h00};
                end else if (haddr_in[7:0] ==
                             comparator_pkg::FLAG_OFFSET) begin
                    state_next.rdata = {5'h00, state_next.flag};
                end else if (haddr_in[7:0] ==
                             comparator_pkg::IST_OFFSET) begin
                    state_next.rdata = {5'h00, state_next.ist};
                end else if (haddr_in[7:0] ==
                             comparator_pkg::MASK_OFFSET) begin
                    state_next.rdata = {5'h00, state_next.mask};
                end else begin
                    state_next.rdata = 8'h00;
                end
            end
        end

        // Minus input routing; routes missing on the small package are
        // left open rather than falling back to another pin.
        for (int i = 0; i < comparator_pkg::NUM_COMP; i++) begin
            state_next.route[i] = '0;
            case (state_next.ctrl[i][comparator_pkg::MINUS_HI:
                                     comparator_pkg::MINUS_LO])
                comparator_pkg::MINUS_B: begin
                    state_next.route[i][comparator_pkg::ROUTE_B] = 1'b1;
                end
                comparator_pkg::MINUS_C: begin
                    state_next.route[i][comparator_pkg::ROUTE_C] =
                        !(SMALL_PACKAGE && i != 2);
                end
                comparator_pkg::MINUS_SHARED: begin
                    if (i == 1) begin
                        state_next.route[i][comparator_pkg::ROUTE_SECOND] =
                            !SMALL_PACKAGE;
                    end else begin
                        state_next.route[i][comparator_pkg::ROUTE_SHARED] =
                            1'b1;
                    end
                end
                default: begin
                    state_next.route[i][comparator_pkg::ROUTE_BANDGAP] =
                        1'b1;
                end
            endcase
        end

        state_next.irq = |(state_next.ist & state_next.mask);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg.ctrl    <= {3{comparator_pkg::CTRL_RESET}};
            state_reg.flag    <= comparator_pkg::FLAG_RESET;
            state_reg.ist     <= comparator_pkg::IST_RESET;
            state_reg.mask    <= comparator_pkg::MASK_RESET;
            state_reg.wr_pend <= 1'b0;
            state_reg.wr_addr <= 8'h00;
            state_reg.rdata   <= 8'h00;
            state_reg.route   <= '0;
            state_reg.irq     <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hrdata_out    = {24'h000000, state_reg.rdata};
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign irq_out       = state_reg.irq;
    assign edge_event_flag_out = state_reg.flag;
    assign minus_route_out     = state_reg.route;

    for (genvar i = 0; i < comparator_pkg::NUM_COMP; i++) begin : g_out
        assign comparator_on_out[i] =
            state_reg.ctrl[i][comparator_pkg::ON_BIT];
        assign plus_source_select_out[i] =
            state_reg.ctrl[i][comparator_pkg::PLUS_BIT];
        // The pin follows the same polarity-corrected result as status.
        assign result_pin_out[i] = result_bits[i];
        assign result_pin_oe_out[i] =
            state_reg.ctrl[i][comparator_pkg::ON_BIT] &&
            state_reg.ctrl[i][comparator_pkg::PIN_BIT];
    end

    auto_flag_a : assert property (
        @(posedge clk_in) disable iff (rst_in)
        (state_reg.wr_pend &&
         state_reg.wr_addr == comparator_pkg::CTRL0_OFFSET &&
         hwdata_in[comparator_pkg::EDGE_HI:comparator_pkg::EDGE_LO] ==
             comparator_pkg::EDGE_ANY)
        |=> edge_event_flag_out[0])
        else $error("any-change select did not set event flag");

    flag_sticky_a : assert property (
        @(posedge clk_in) disable iff (rst_in)
        (edge_event_flag_out[1] &&
         !(state_reg.wr_pend &&
           state_reg.wr_addr == comparator_pkg::FLAG_OFFSET))
        |=> edge_event_flag_out[1])
        else $error("event flag dropped without a write");

    status_read_a : assert property (
        @(posedge clk_in) disable iff (rst_in)
        (addr_phase && !hwrite_in &&
         haddr_in[7:0] == comparator_pkg::STATUS_OFFSET)
        |=> hrdata_out[4:0] == 5'h00 &&
            hrdata_out[7:5] == $past(result_bits))
        else $error("status read returned wrong layout");

    pin_drive_a : assert property (
        @(posedge clk_in) disable iff (rst_in)
        (state_reg.wr_pend &&
         state_reg.wr_addr == comparator_pkg::CTRL0_OFFSET &&
         hwdata_in[7:6] == 2'h1)
        |=> !result_pin_oe_out[0] ##1 !result_pin_oe_out[0] ||
            state_reg.wr_pend)
        else $error("pin driven while comparator off");

    second_route_a : assert property (
        @(posedge clk_in) disable iff (rst_in)
        !minus_route_out[1][comparator_pkg::ROUTE_SHARED] &&
        !minus_route_out[0][comparator_pkg::ROUTE_SECOND])
        else $error("shared minus route on wrong comparator");

    small_pkg_a : assert property (
        @(posedge clk_in) disable iff (rst_in)
        SMALL_PACKAGE |-> !minus_route_out[0][comparator_pkg::ROUTE_C] &&
                          !minus_route_out[1][comparator_pkg::ROUTE_C] &&
                          !minus_route_out[1][comparator_pkg::ROUTE_SECOND])
        else $error("absent pin routed on small package");

    reset_off_a : assert property (
        @(posedge clk_in) disable iff (1'b0)
        rst_in |=> comparator_on_out == 3'h0 && !irq_out)
        else $error("comparator on after reset");

    irq_level_a : assert property (
        @(posedge clk_in) disable iff (rst_in)
        (|(events & state_reg.mask)) |=> irq_out [*2])
        else $error("unmasked event did not hold interrupt");

endmodule // comparator_control

// ---- logic/comparator_pkg.sv ----
package comparator_pkg;

    // Number of comparators served by one register map.
    localparam int NUM_COMP = 3;

    // Byte offsets of the word-aligned registers on the bus.
    localparam logic [7:0] CTRL0_OFFSET  = 8'h00;
    localparam logic [7:0] CTRL1_OFFSET  = 8'h04;
    localparam logic [7:0] CTRL2_OFFSET  = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0C;
    localparam logic [7:0] FLAG_OFFSET   = 8'h10;
    localparam logic [7:0] IST_OFFSET    = 8'h14;
    localparam logic [7:0] MASK_OFFSET   = 8'h18;

    // Control register field positions.
    localparam int ON_BIT   = 7;
    localparam int PIN_BIT  = 6;
    localparam int INV_BIT  = 5;
    localparam int EDGE_HI  = 4;
    localparam int EDGE_LO  = 3;
    localparam int PLUS_BIT = 2;
    localparam int MINUS_HI = 1;
    localparam int MINUS_LO = 0;

    // Result bits sit in the top three bits of the status register.
    localparam int STATUS_LSB = 5;
    localparam int STATUS_MSB = 7;

    // Reset values.
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [2:0] FLAG_RESET  = 3'h0;
    localparam logic [2:0] IST_RESET   = 3'h0;
    localparam logic [2:0] MASK_RESET  = 3'h0;

    // Event edge select codes.
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_ANY  = 2'h3;

    // Minus channel select codes.
    localparam logic [1:0] MINUS_B        = 2'h0;
    localparam logic [1:0] MINUS_C        = 2'h1;
    localparam logic [1:0] MINUS_SHARED   = 2'h2;
    localparam logic [1:0] MINUS_BANDGAP  = 2'h3;

    // One-hot positions of the minus input route.
    localparam int ROUTE_B       = 0;
    localparam int ROUTE_C       = 1;
    localparam int ROUTE_SHARED  = 2;
    localparam int ROUTE_SECOND  = 3;
    localparam int ROUTE_BANDGAP = 4;
    localparam int ROUTE_W       = 5;

endpackage
